// ---- hdl/pbc_pkg.sv ----
// Purpose: Shared constants and types for the bus control signal block.
// Assumes: One 20 MHz clock, active-low bus pins represented as levels.
// Notes:   Bus control pins are active low on the wire, high here internally.
package pbc_pkg;

	localparam int          CLK_PERIOD_NS     = 50;
	localparam int          BUS_CLK_MAX_MHZ   = 33;
	localparam int          TARGET_RESP_CYC   = 6;
	localparam logic [2:0]  TIMEOUT_CYC       = 3'h6;
	localparam logic [3:0]  CMD_CFG_READ      = 4'hA;
	localparam logic [3:0]  CMD_CFG_WRITE     = 4'hB;
	localparam int          NUM_CHAN          = 4;
	localparam logic [3:0]  RTS_IDLE          = 4'hF;
	localparam logic        PAR_DEMULTIPLEXED_BUS_MODE_LEVEL   = 1'h0;

	typedef enum logic [1:0] {
		PBC_IDLE = 2'h0,
		PBC_WAIT = 2'h1,
		PBC_ADDR = 2'h3,
		PBC_DATA = 2'h2
	} pbc_mst_e;

	// One address/data phase as seen on the shared lines.
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe;
		logic        par;
	} pbc_phase_s;

endpackage

// ---- hdl/pbc_parity.sv ----
// Purpose: Even parity check over AD and C/BE with a two cycle report.
// Assumes: Phase lines are valid in the cycle marked by check_en.
// Notes:   The received parity bit arrives one cycle after its data.
`timescale 1ns/1ps
`default_nettype none
module pbc_parity
	import pbc_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Sampled bus phase
	input  wire pbc_phase_s phase,
	input  wire logic       check_en,
	// Error report
	output logic            perr
);

	logic       held_par;
	logic       held_en;
	wire logic  calc_par = ^{phase.ad, phase.cbe};
	wire logic  mismatch = held_en & (held_par != phase.par);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			held_par <= 1'h0;
			held_en  <= 1'h0;
			perr     <= 1'h0;
		end else begin
			held_par <= calc_par;
			held_en  <= check_en;
			perr     <= mismatch;
		end
	end

	a_perr_two_cyc: assert property (@(posedge ref_clk) disable iff (!rstn)
		check_en ##1 (phase.par != $past(calc_par)) |=> perr)
		else $error("parity error not reported two cycles later");

	c_perr_seen: cover property (@(posedge ref_clk) disable iff (!rstn)
		perr);

endmodule
`default_nettype wire

// ---- hdl/pbc_timeout.sv ----
// Purpose: Counts cycles from address output until target response.
// Assumes: start is a one cycle pulse in the address phase.
// Notes:   Expiry is a one cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module pbc_timeout
	import pbc_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Control
	input  wire logic start,
	input  wire logic seen,
	// Result
	output logic      expired
);

	logic       running;
	logic [2:0] count;
	wire logic  at_limit = running & ~seen & (count == TIMEOUT_CYC);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			running <= 1'h0;
			count   <= 3'h0;
			expired <= 1'h0;
		end else begin
			running <= start | (running & ~seen & ~at_limit);
			count   <= start ? 3'h1 : count + 3'h1;
			expired <= at_limit;
		end
	end

	a_timeout_fires: assert property (@(posedge ref_clk) disable iff (!rstn)
		start ##1 (!seen)[*6] |=> expired)
		else $error("master abort not raised after six cycles");

endmodule
`default_nettype wire

// ---- hdl/pbc_ctrl.sv ----
// Function
// - Config access on select plus config command.
// - Assert device select cycle after address.
// - Sample initialization select every rising edge.
// - Demultiplexed_bus_mode mode: select alone addresses config.
// - No device select in six: abort, interrupt.
// - Drive device select as slave only.
// - Device select works in demultiplexed_bus_mode mode too.
// - Flag parity error on even parity mismatch.
// - Parity error two cycles after phase.
// - Assert system error on fatal error.
// - Assert request on edge for ownership.
// - After grant, start once frame released.
// - Sample grant every rising edge.
// - Reset brings all state to initial.
// - Reset: outputs benign, bidirectionals inputs.
// - Reset: transmit outputs high impedance.
// - Reset: request-to-send outputs inactive.
// - Demultiplexed_bus_mode mode: parity output held zero.
//
// Purpose: Bus control signal sequencing for slave and master roles.
// Assumes: Pins are active high internally; pads invert and resolve.
// Notes:   Frame/ready handshakes and the data path live elsewhere.
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl
	import pbc_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Mode and sampled bus phase
	input  wire logic       demultiplexed_bus_mode,
	input  wire pbc_phase_s phase,
	input  wire logic       addr_phase,
	input  wire logic       data_phase,
	input  wire logic       idsel,
	input  wire logic       frame_in,
	input  wire logic       gnt,
	input  wire logic       devsel_in,
	// Internal requests
	input  wire logic       mst_start,
	input  wire logic       fatal_err,
	input  wire logic       par_drive,
	// Device select pin
	output logic            devsel_out,
	output logic            devsel_oe,
	// Parity pin
	output logic            par_out,
	output logic            par_oe,
	// Error pins
	output logic            perr_out,
	output logic            perr_oe,
	output logic            serr_oe,
	// Arbitration and master status
	output logic            req,
	output logic            mst_addr,
	output logic            mst_abort,
	output logic            inta,
	// Slave status
	output logic            cfg_hit,
	// Serial channel pins
	output logic [3:0]      channel_serial_transmit_oe,
	output logic [3:0]      channel_request_to_send_out
);

	////////////////////////////////////////////////////////////////////////
	// Slave decode.

	pbc_mst_e state;
	pbc_mst_e next_state;

	wire logic is_cfg_cmd = (phase.cbe == CMD_CFG_READ) |
	                        (phase.cbe == CMD_CFG_WRITE);
	// Demultiplexed_bus_mode mode has no config command, so select alone is the chip select.
	wire logic cfg_decode = addr_phase & idsel &
	                        (demultiplexed_bus_mode | is_cfg_cmd);
	wire logic slave_act  = state == PBC_IDLE;
	wire logic perr_flag;
	wire logic timeout;

	// Decoded straight from the sampled pins, because an extra input stage
	// would push device select two cycles past the address phase.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_hit    <= 1'h0;
			devsel_out <= 1'h0;
			devsel_oe  <= 1'h0;
		end else begin
			cfg_hit    <= cfg_decode & slave_act;
			devsel_out <= cfg_decode & slave_act;
			devsel_oe  <= cfg_decode & slave_act;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master arbitration and address phase.

	logic gnt_q;
	logic frame_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gnt_q   <= 1'h0;
			frame_q <= 1'h0;
		end else begin
			gnt_q   <= gnt;
			frame_q <= frame_in;
		end
	end

	// A grant is only used once the previous owner has released frame.
	wire logic bus_free = gnt_q & ~frame_q & ~frame_in;

	always_comb begin
		next_state = state;
		unique case (state)
			PBC_IDLE: if (mst_start) next_state = PBC_WAIT;
			PBC_WAIT: if (bus_free) next_state = PBC_ADDR;
			PBC_ADDR: next_state = PBC_DATA;
			PBC_DATA: if (devsel_in | timeout) next_state = PBC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= PBC_IDLE;
			req      <= 1'h0;
			mst_addr <= 1'h0;
		end else begin
			state    <= next_state;
			req      <= next_state == PBC_WAIT;
			mst_addr <= next_state == PBC_ADDR;
		end
	end

	pbc_timeout u_timeout (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.start   (mst_addr),
		.seen    (devsel_in),
		.expired (timeout)
	);

	// The interrupt level stays up until the next master start.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mst_abort <= 1'h0;
			inta      <= 1'h0;
		end else begin
			mst_abort <= timeout;
			inta      <= timeout | (inta & ~mst_start);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parity and system error.

	pbc_parity u_parity (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.phase    (phase),
		.check_en (addr_phase | data_phase),
		.perr     (perr_flag)
	);

	wire logic par_calc = ^{phase.ad, phase.cbe};

	// The checker's own flop already lands in the cycle after the parity bit.
	assign perr_out = perr_flag;
	assign perr_oe  = perr_flag;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			par_out  <= 1'h0;
			par_oe   <= 1'h0;
			serr_oe  <= 1'h0;
		end else begin
			par_out  <= demultiplexed_bus_mode ? PAR_DEMULTIPLEXED_BUS_MODE_LEVEL
			                                   : par_calc;
			par_oe   <= par_drive | demultiplexed_bus_mode;
			serr_oe  <= fatal_err;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial channel pins held safe in reset.

	for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				channel_serial_transmit_oe[i]  <= 1'h0;
				channel_request_to_send_out[i] <= RTS_IDLE[i];
			end else begin
				channel_serial_transmit_oe[i]  <= 1'h1;
				channel_request_to_send_out[i] <= RTS_IDLE[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_devsel_next_cyc: assert property (@(posedge ref_clk) disable iff (!rstn)
		(addr_phase && idsel && is_cfg_cmd && slave_act)
		|=> devsel_out && devsel_oe)
		else $error("device select not asserted after config address");

	a_demultiplexed_bus_mode_select: assert property (@(posedge ref_clk) disable iff (!rstn)
		(demultiplexed_bus_mode && addr_phase && idsel && slave_act)
		|=> cfg_hit)
		else $error("demultiplexed_bus_mode chip select ignored");

	a_no_cfg_hit: assert property (@(posedge ref_clk) disable iff (!rstn)
		(addr_phase && !idsel) |=> !cfg_hit)
		else $error("config hit without select");

	a_devsel_master_off: assert property (@(posedge ref_clk)
		disable iff (!rstn)
		!slave_act |=> !devsel_oe)
		else $error("device select driven while master");

	a_abort_six: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(mst_addr) ##0 (!devsel_in)[*7] |=> ##1 inta)
		else $error("no interrupt after master abort");

	a_req_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
		req |-> state == PBC_WAIT)
		else $error("request outside wait state");

	a_start_frame: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(mst_addr) |-> $past(gnt_q) && !$past(frame_in))
		else $error("master started without free bus");

	a_par_demultiplexed_bus_mode: assert property (@(posedge ref_clk) disable iff (!rstn)
		demultiplexed_bus_mode |=> !par_out)
		else $error("parity driven in demultiplexed_bus_mode mode");

	a_serr_fatal: assert property (@(posedge ref_clk) disable iff (!rstn)
		fatal_err |=> serr_oe)
		else $error("system error not asserted");

	a_rts_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(rstn) |-> channel_request_to_send_out == RTS_IDLE)
		else $error("request-to-send active after reset");

	c_cfg_access: cover property (@(posedge ref_clk) disable iff (!rstn)
		cfg_hit);
	c_master_abort: cover property (@(posedge ref_clk) disable iff (!rstn)
		mst_abort);
	c_master_ok: cover property (@(posedge ref_clk) disable iff (!rstn)
		(state == PBC_DATA) && devsel_in);

endmodule
`default_nettype wire

// ---- tb/pbc_bus_peer.sv ----
// Purpose: Arbiter and target model facing the block's master side.
// Assumes: Request level and address pulse come from the block under test.
// Notes:   answer_dly of zero means no target ever claims the access.
`timescale 1ns/1ps
`default_nettype none
module pbc_bus_peer
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// From the block, plus answer_dly set by the bench
	input  wire logic req,
	input  wire logic mst_addr,
	input  wire logic [3:0] answer_dly,
	// To the block
	output logic      gnt,
	output logic      devsel_in
);
	logic [3:0] cnt;
	logic       run;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			gnt       <= 1'h0;
			devsel_in <= 1'h0;
			cnt       <= 4'h0;
			run       <= 1'h0;
		end else begin
			gnt       <= req;
			devsel_in <= run && answer_dly != 4'h0 && cnt == answer_dly;
			cnt       <= mst_addr ? 4'h1 : cnt + 4'h1;
			run       <= mst_addr | (run && cnt != 4'hF);
		end
	end
endmodule
`default_nettype wire

// ---- tb/pbc_ctrl_tb.sv ----
// Purpose: Self-checking bench for the bus control signal block.
// Assumes: Active-high internal pin levels as the block presents them.
// Notes:   Random bus words come from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl_tb;
	import pbc_pkg::*;
	logic ref_clk = 0, rstn = 0, mode = 0, addr_phase = 0, data_phase = 0;
	logic idsel = 0, frame_in = 0, mst_start = 0, fatal_err = 0;
	logic par_drive = 0, gnt, devsel_in, devsel_out, devsel_oe, par_out;
	logic par_oe, perr_out, perr_oe, serr_oe, req, mst_addr, mst_abort;
	logic inta, cfg_hit;
	logic [3:0] tx_oe, rts, dly = 4'h0;
	pbc_phase_s ph = '0;
	logic [31:0] seed = 32'h0DD30499;
	int fail_count = 0, cmp_count = 0, n;

	always #25 ref_clk = ~ref_clk;

	pbc_ctrl i_dut (.ref_clk(ref_clk), .rstn(rstn),
		.demultiplexed_bus_mode(mode), .phase(ph), .addr_phase(addr_phase),
		.data_phase(data_phase), .idsel(idsel), .frame_in(frame_in),
		.gnt(gnt), .devsel_in(devsel_in), .mst_start(mst_start),
		.fatal_err(fatal_err), .par_drive(par_drive),
		.devsel_out(devsel_out), .devsel_oe(devsel_oe), .par_out(par_out),
		.par_oe(par_oe), .perr_out(perr_out), .perr_oe(perr_oe),
		.serr_oe(serr_oe), .req(req), .mst_addr(mst_addr),
		.mst_abort(mst_abort), .inta(inta), .cfg_hit(cfg_hit),
		.channel_serial_transmit_oe(tx_oe),
		.channel_request_to_send_out(rts));

	pbc_bus_peer i_peer (.ref_clk(ref_clk), .rstn(rstn), .req(req),
		.mst_addr(mst_addr), .answer_dly(dly), .gnt(gnt),
		.devsel_in(devsel_in));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Benign levels while reset is held.
	task automatic chk_reset();
		chk({devsel_oe, par_oe, perr_oe, serr_oe, req, inta}, 0);
		chk({devsel_out, par_out, perr_out, mst_addr, mst_abort, cfg_hit},
			0);
		chk(tx_oe, 4'h0);
		chk(rts, RTS_IDLE);
	endtask

	task automatic cfg(input logic [3:0] cmd, input logic sel, input logic e);
		@(posedge ref_clk);
		addr_phase <= 1'h1;
		idsel      <= sel;
		ph.cbe     <= cmd;
		ph.ad      <= rnd();
		@(posedge ref_clk);
		addr_phase <= 1'h0;
		idsel      <= 1'h0;
		#1 chk({cfg_hit, devsel_oe, devsel_out}, {3{e}});
		@(posedge ref_clk);
		#1 chk(devsel_oe, 0);
	endtask

	task automatic par_t(input logic bad, input logic dp);
		logic [31:0] a;
		logic [3:0]  c;
		a = rnd();
		c = a[7:4];
		@(posedge ref_clk);
		addr_phase <= !dp;
		data_phase <= dp;
		ph.ad      <= a;
		ph.cbe     <= c;
		@(posedge ref_clk);
		addr_phase <= 1'h0;
		data_phase <= 1'h0;
		ph.par     <= ^{a, c} ^ bad;
		#1 chk(par_out, ^{a, c});
		@(posedge ref_clk);
		#1 chk({perr_out, perr_oe}, {2{bad}});
	endtask

	// Another master holds the frame for a while before the grant is used.
	task automatic mst(input logic [3:0] d, input logic ab);
		dly = d;
		@(posedge ref_clk);
		mst_start <= 1'h1;
		frame_in  <= 1'h1;
		@(posedge ref_clk);
		mst_start  <= 1'h0;
		addr_phase <= 1'h1;
		idsel      <= 1'h1;
		ph.cbe     <= CMD_CFG_READ;
		@(posedge ref_clk);
		addr_phase <= 1'h0;
		idsel      <= 1'h0;
		#1 chk(cfg_hit, 0);
		repeat (3) @(posedge ref_clk);
		#1 chk({req, mst_addr}, 2'h2);
		frame_in <= 1'h0;
		n = 0;
		while (!mst_addr && n < 30) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(mst_addr, 1);
		n = 0;
		while (!mst_abort && n < 12) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(mst_abort, ab);
		if (ab)
			chk(n, TARGET_RESP_CYC + 2);
		@(posedge ref_clk);
		#1 chk(inta, ab);
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		chk_reset();
		repeat (6) @(posedge ref_clk);
		rstn <= 1'h1;
		for (int m = 0; m < 2; m++) begin
			mode <= m[0];
			for (int c = 0; c < 16; c++)
				cfg(c[3:0], 1'h1, m[0] | c == CMD_CFG_READ | c == CMD_CFG_WRITE);
			cfg(CMD_CFG_READ, 1'h0, 1'h0);
		end
		par_drive <= 1'h1;
		repeat (3) @(posedge ref_clk);
		#1 chk(par_out, PAR_DEMULTIPLEXED_BUS_MODE_LEVEL);
		chk(par_oe, 1);
		par_drive <= 1'h0;
		mode      <= 1'h0;
		par_t(1'h1, 1'h0);
		par_t(1'h0, 1'h1);
		for (int i = 0; i < 20; i++)
			par_t(rnd() > 32'h7FFFFFFF, i[0]);
		fatal_err <= 1'h1;
		repeat (3) @(posedge ref_clk);
		#1 chk(serr_oe, 1);
		fatal_err <= 1'h0;
		mst(4'h2, 1'h0);
		mst(4'h0, 1'h1);
		rstn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk_reset();
		rstn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		#1 chk(tx_oe, 4'hF);
		chk(rts, RTS_IDLE);
		give_verdict();
	end
endmodule
`default_nettype wire
